// ---- irc_pkg.sv ----
/*
  constants, register map and state layout of the infrared pulse codec.
  assumes a 25 mhz system clock and a serial channel on the same clock.

  // Overview of operation
  // RULE1: zero bits send high pulse, default 3/16
  // RULE2: bits six to four select pulse width
  // RULE3: received pulses rebuilt into plain serial frames
  // RULE4: bit seven enables codec, resets to zero
  // RULE5: software keeps reserved bits three, two zero
  // RULE6: no polarity inversion on either pin
  // RULE7: one bits keep pin low; pulse yields zero
*/
package irc_pkg;
  // time base
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_HZ = 115200;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_HZ);
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DIV_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  // control field positions and reset values
  localparam int EN_BIT = 7;
  localparam int WSEL_HI = 6;
  localparam int WSEL_LO = 4;
  localparam logic EN_RST = 1'b0;
  localparam logic [2:0] WSEL_RST = 3'h3;
  // transmit bit buffer
  localparam int FIFO_W = 1;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic en;
    logic [2:0] wsel;
    logic [15:0] div;
    logic ack;
    logic [31:0] rdat;
    logic [15:0] tx_cnt;
    logic tx_act;
    logic tx_bit;
    logic ir_tx;
    logic plain_tx;
    logic [2:0] ir_sync;
    logic [1:0] plain_sync;
    logic [15:0] rx_cnt;
    logic sci_rxd;
  } irc_state_s;
endpackage

// ---- irc_stream_if.sv ----
/*
  push and pop handshake between the codec and its bit buffer.
  assumes both ends run on the same clock.
*/
interface irc_stream_if #(
  parameter int W = 1
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport buffer (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

// ---- irc_fifo.sv ----
/*
  synchronous fifo with registered full and empty flags.
  assumes one clock and a synchronous active high reset.
*/
module irc_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  irc_stream_if.buffer s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
    logic some;
  } irc_fifo_s;

  irc_fifo_s q_r;
  irc_fifo_s q_nxt;
  logic do_push;
  logic do_pop;

  // flags are registered copies taken from the next count, so ready leaves on a flop
  assign s.push_ready = q_r.room;
  assign s.pop_valid = q_r.some;
  assign s.pop_data = q_r.mem[q_r.rp];
  assign do_push = s.push_valid && s.push_ready;
  assign do_pop = s.pop_ready && s.pop_valid;

  // pointer and count update
  always_comb
  begin
    q_nxt = q_r;
    if (do_push)
    begin
      q_nxt.mem[q_r.wp] = s.push_data;
      q_nxt.wp = (q_r.wp == AW'(DEPTH - 1)) ? '0 : q_r.wp + 1'b1;
    end
    if (do_pop)
      q_nxt.rp = (q_r.rp == AW'(DEPTH - 1)) ? '0 : q_r.rp + 1'b1;
    if (do_push && !do_pop)
      q_nxt.cnt = q_r.cnt + 1'b1;
    else if (do_pop && !do_push)
      q_nxt.cnt = q_r.cnt - 1'b1;
    // flags follow the count that the next edge will hold
    q_nxt.room = (q_nxt.cnt != (AW + 1)'(DEPTH));
    q_nxt.some = (q_nxt.cnt != '0);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
      q_r.room <= 1'b1; // empty buffer accepts at once
    end
    else
      q_r <= q_nxt;
  end
endmodule

// ---- irc_codec.sv ----
/*
  infrared pulse codec between serial channel one and the infrared pins,
  with a classic wishbone register slave.
  assumes the serial channel hands over transmit bits one at a time on
  the same clock, and that the infrared receive pin is asynchronous.
*/
module irc_codec #(
  parameter int FIFO_W_P = irc_pkg::FIFO_W,
  parameter int FIFO_DEPTH_P = irc_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic tx_valid_i,
  input wire logic tx_bit_i,
  output logic tx_ready_o,
  output logic serial_rxd_o,
  output logic infrared_transmit_pin_o,
  input wire logic infrared_receive_pin_i,
  output logic plain_txd_o,
  input wire logic plain_rxd_i
);
  import irc_pkg::*;

  irc_state_s q_r;
  irc_state_s q_nxt;
  logic tx_full;
  logic [18:0] prod;
  logic [15:0] width;
  logic bit_end;
  logic req;

  irc_stream_if #(.W(FIFO_W_P)) st ();

  irc_fifo #(
    .W(FIFO_W_P),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(st.user)
  );

  // the serial channel pushes straight in; ready is the fifo's own flag
  assign st.push_valid = tx_valid_i;
  assign st.push_data = FIFO_W_P'(tx_bit_i);
  assign tx_ready_o = st.push_ready;
  assign tx_full = !st.push_ready;

  // pulse width in cycles: wsel sixteenths of a bit, never under one cycle
  assign prod = 19'(q_r.div) * 19'(q_r.wsel);
  assign width = (prod[18:4] == '0) ? 16'h0001 : {1'b0, prod[18:4]}; // RULE2

  // a bit slot ends after div cycles; a zero divisor acts as one
  assign bit_end = !q_r.tx_act || (q_r.tx_cnt + 16'h0001 >= q_r.div);
  assign st.pop_ready = bit_end;
  assign req = wb_cyc_i && wb_stb_i && !q_r.ack;

  always_comb
  begin
    q_nxt = q_r;
    // wishbone: answer one cycle after the request, drop ack right after
    q_nxt.ack = req;
    q_nxt.rdat = '0;
    if (req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == CTRL_OFS)
      begin
        q_nxt.en = wb_dat_i[EN_BIT]; // RULE4
        q_nxt.wsel = wb_dat_i[WSEL_HI:WSEL_LO]; // RULE2
        // bits 3..2 hold nothing; software keeps them zero (RULE5)
      end
      if (wb_adr_i == DIV_OFS)
        q_nxt.div[7:0] = wb_dat_i[7:0];
    end
    if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == DIV_OFS)
      q_nxt.div[15:8] = wb_dat_i[15:8];
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        CTRL_OFS: q_nxt.rdat = 32'({q_r.en, q_r.wsel, 4'h0}); // RULE4 RULE5
        DIV_OFS: q_nxt.rdat = 32'(q_r.div);
        STAT_OFS: q_nxt.rdat = 32'({tx_full, st.pop_valid, q_r.rx_cnt != '0, q_r.tx_act});
        default: q_nxt.rdat = '0; // unmapped offsets read zero and still ack
      endcase
    end

    // transmit: take one buffered bit per bit interval
    if (bit_end)
    begin
      q_nxt.tx_cnt = '0;
      q_nxt.tx_act = st.pop_valid;
      q_nxt.tx_bit = st.pop_valid ? st.pop_data[0] : 1'b1;
    end
    else
      q_nxt.tx_cnt = q_r.tx_cnt + 16'h0001;
    // zero bits give an active high pulse at the slot start, ones stay low
    q_nxt.ir_tx = q_r.en && q_nxt.tx_act && !q_nxt.tx_bit
      && (q_nxt.tx_cnt < width); // RULE1 RULE6 RULE7
    // with the codec off the bits leave unchanged on the plain line
    q_nxt.plain_tx = q_r.en ? 1'b1 : q_nxt.tx_bit; // RULE4

    // receive pins pass two flops; no inversion anywhere on the way
    q_nxt.ir_sync = {q_r.ir_sync[1:0], infrared_receive_pin_i}; // RULE6
    q_nxt.plain_sync = {q_r.plain_sync[0], plain_rxd_i};
    // a rising pulse edge restarts a one-bit-long zero
    if (q_r.ir_sync[1] && !q_r.ir_sync[2])
      q_nxt.rx_cnt = (q_r.div == '0) ? 16'h0001 : q_r.div; // RULE3 RULE7
    else if (q_r.rx_cnt != '0)
      q_nxt.rx_cnt = q_r.rx_cnt - 16'h0001;
    if (q_r.en)
      q_nxt.sci_rxd = (q_nxt.rx_cnt == '0); // RULE3 RULE7
    else
      q_nxt.sci_rxd = q_r.plain_sync[1]; // RULE4
  end

  // single register stage for all state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
      q_r.en <= EN_RST;
      q_r.wsel <= WSEL_RST;
      q_r.div <= DIV_RST;
      q_r.tx_bit <= 1'b1;
      q_r.plain_tx <= 1'b1;
      q_r.sci_rxd <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign wb_ack_o = q_r.ack;
  assign wb_dat_o = q_r.rdat;
  assign serial_rxd_o = q_r.sci_rxd;
  assign infrared_transmit_pin_o = q_r.ir_tx;
  assign plain_txd_o = q_r.plain_tx;
endmodule

// ---- irc_optics.sv ----
/* infrared optics model: a request becomes a light pulse on the receive pin.
   assumes the bench clock. */
module irc_optics (
  input wire logic clk_i,
  input wire logic fire_i,
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] sh_r = 2'b00;
  // two-cycle high pulse, idle low like a dark photodiode
  always_ff @(posedge clk_i)
    sh_r <= {sh_r[0], fire_i};
  assign rx_o = |sh_r;
endmodule

// ---- irc_codec_sva.sv ----
/* port assertions for the pulse codec.
   assumes one clock; the enable shadow follows taken wishbone writes. */
module irc_codec_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_ready_o,
  input wire logic serial_rxd_o,
  input wire logic infrared_transmit_pin_o,
  input wire logic infrared_receive_pin_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic en_r;
  // shadow of the enable bit, updated at the edge the slave takes a write
  always_ff @(posedge clk_i)
    if (rst_i)
      en_r <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0)
      en_r <= wb_dat_i[7];
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
  property p_rd_en;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0 |-> wb_dat_o[7] == en_r;
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback");
  property p_rx_zero; en_r && $rose(infrared_receive_pin_i) |-> ##[2:5] !serial_rxd_o; endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("no receive zero");
  property p_rxd_hold; en_r && $fell(serial_rxd_o) |=> !serial_rxd_o [*8]; endproperty
  a_rxd_hold: assert property (p_rxd_hold) else $error("zero too short");
  property p_tx_off; !en_r && !$past(en_r) |-> !infrared_transmit_pin_o; endproperty
  a_tx_off: assert property (p_tx_off) else $error("pulse while off");
  property p_rst; $past(rst_i) |-> tx_ready_o && serial_rxd_o && !infrared_transmit_pin_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_tx: cover property ($rose(infrared_transmit_pin_o));
  c_rx: cover property ($fell(serial_rxd_o));
  c_full: cover property (!tx_ready_o);
endmodule
bind irc_codec irc_codec_sva irc_codec_sva_inst (.clk_i, .rst_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .tx_ready_o, .serial_rxd_o, .infrared_transmit_pin_o,
  .infrared_receive_pin_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o);

// ---- irc_codec_test.sv ----
/* bench for the pulse codec: registers, pulse widths, receive, buffer.
   assumes package, fifo, codec, optics and checker are compiled first. */
module irc_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  typedef struct packed {logic [3:0] a; logic w; logic [31:0] d, e;} irc_row_s;
  irc_row_s rows [7] = '{'{4'h0, 1'b0, 32'h0, 32'h30}, '{4'h4, 1'b0, 32'h0, 32'hd9},
    '{4'h0, 1'b1, 32'hb0, 32'h0}, '{4'h0, 1'b0, 32'h0, 32'hb0}, '{4'hc, 1'b1, 32'hff, 32'h0},
    '{4'hc, 1'b0, 32'h0, 32'h0}, '{4'h8, 1'b0, 32'h0, 32'h0}};
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, tv = 1'b0, tb = 1'b1, fire = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, rdy, srx, irtx, irrx, ptx;
  logic prx = 1'b1;
  int n_fail = 0, samples_checked = 0, k;
  integer c; // four-state, so an unknown pin spoils the count
  irc_codec irc_codec_inst (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
    .tx_valid_i(tv), .tx_bit_i(tb), .tx_ready_o(rdy), .serial_rxd_o(srx),
    .infrared_transmit_pin_o(irtx), .infrared_receive_pin_i(irrx), .plain_txd_o(ptx),
    .plain_rxd_i(prx));
  irc_optics irc_optics_inst (.clk_i, .fire_i(fire), .rx_o(irrx));
  always #20 clk_i = ~clk_i;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled high; a lost ack ends the run
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_fail++;
      wrap_up;
    end
  endtask
  task automatic push(input logic b);
    @(posedge clk_i);
    tv <= 1'b1;
    tb <= b;
    @(posedge clk_i);
    tv <= 1'b0;
  endtask
  // counts pulse cycles, receive zero cycles, refused cycles or plain low cycles
  task automatic cnt(input int n, input int m);
    c = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      c += (m == 0) ? irtx : (m == 1) ? !srx : (m == 2) ? !rdy : !ptx;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk("reg", rows[i].e, q);
    end
    push(1'b0);
    cnt(300, 0);
    chk("pulse", 40, c);
    bus(4'h4, 1'b1, 32'h10);
    for (int w = 0; w < 8; w++)
    begin
      bus(4'h0, 1'b1, 32'h80 | 32'(w << 4));
      push(1'b0);
      cnt(48, 0);
      chk("width", (w == 0) ? 1 : w, c);
    end
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    cnt(40, 1);
    chk("rx", 16, c);
    tv <= 1'b1;
    tb <= 1'b1;
    cnt(40, 2);
    tv <= 1'b0;
    chk("full", 1, c > 0);
    cnt(600, 0);
    chk("ones", 0, c);
    bus(4'h8, 1'b0, 32'h0);
    chk("drained", 32'h0, q);
    // reset in mid-run with the codec enabled: enable and divisor return
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(4'h0, 1'b0, 32'h0);
    chk("ctrl after reset", 32'h30, q);
    bus(4'h4, 1'b0, 32'h0);
    chk("div after reset", 32'(DIV_RST), q);
    chk("idle rxd", 1, srx);
    // codec off: a zero bit spans a whole slot on the plain line
    push(1'b0);
    cnt(300, 3);
    chk("plain tx", 32'(DIV_RST), c);
    // codec off: the plain receive line reaches the serial channel after its flops
    prx <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("plain rx low", 0, srx);
    prx <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("plain rx high", 1, srx);
    wrap_up;
  end
endmodule
